// File: hdl/cpl_desc_decode.sv
`timescale 1ns/1ps
module cpl_desc_decode (
  input wire logic [cq_frame_pkg::DESC_BITS-1:0] desc_i,
  input wire logic aligned_mode_i,
  input wire logic start_upper_i,
  output logic [5:0] payload_lane_o,
  output logic [10:0] dword_count_o,
  output logic [2:0] status_o,
  output logic status_bad_o,
  output logic count_bad_o
);
  import cq_frame_pkg::*;

  logic [5:0] start_lane;
  logic [3:0] low_addr;

  // six-bit sums wrap, which gives the modulo-64 lane for free
  always_comb begin
    start_lane = start_upper_i ? LANE_UPPER : 6'h00;
    low_addr = desc_i[LOWER_ADDR_LSB +: 4];
    status_o = desc_i[STATUS_LSB +: 3];
    dword_count_o = desc_i[DWCOUNT_LSB +: 11];
    if (aligned_mode_i) begin
      payload_lane_o = start_lane + LANE_QW_OFFSET + {2'b00, low_addr};
    end else begin
      payload_lane_o = start_lane + LANE_DW_OFFSET + {4'h0, low_addr[1:0]};
    end
    status_bad_o = !(status_o == CPL_STATUS_SC || status_o == CPL_STATUS_UR
                     || status_o == CPL_STATUS_CA);
    count_bad_o = (status_o == CPL_STATUS_UR || status_o == CPL_STATUS_CA)
                  && (dword_count_o != 11'h000);
  end
endmodule

// File: hdl/cq_frame_pkg.sv
package cq_frame_pkg;
  // stream geometry
  localparam int HALF_BITS = 256;
  localparam int BEAT_BITS = 512;
  localparam int BEAT_BYTES = 64;
  localparam int BEAT_DWORDS = 16;
  localparam int DESC_BITS = 96;
  localparam int APB_AW = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_REQ_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CPL_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_CPL_ERR = 8'h10;

  // control field positions and reset value
  localparam int CTRL_STRADDLE = 0;
  localparam int CTRL_ALIGNED = 1;
  localparam int CTRL_CC_STRADDLE = 2;
  localparam int CTRL_BITS = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // sticky completion error bits
  localparam int ERR_VALID_DROP = 0;
  localparam int ERR_BAD_STATUS = 1;
  localparam int ERR_BAD_COUNT = 2;
  localparam int ERR_BITS = 3;

  // completion descriptor field positions
  localparam int LOWER_ADDR_LSB = 0;
  localparam int DWCOUNT_LSB = 32;
  localparam int STATUS_LSB = 43;

  // completion status encodings
  localparam logic [2:0] CPL_STATUS_SC = 3'h0;
  localparam logic [2:0] CPL_STATUS_UR = 3'h1;
  localparam logic [2:0] CPL_STATUS_CA = 3'h4;

  // lane arithmetic
  localparam logic [5:0] LANE_UPPER = 6'h20;
  localparam logic [5:0] LANE_DW_OFFSET = 6'h0c;
  localparam logic [5:0] LANE_QW_OFFSET = 6'h10;
  localparam logic [3:0] UPPER_DWORD_BASE = 4'h8;
  localparam logic [3:0] EOP1_MIN_PTR = 4'hb;

  typedef enum logic [1:0] {
    SLOT_LOW = 2'b00,
    SLOT_HIGH = 2'b01,
    SLOT_HIGH_NEW = 2'b10
  } slot_t;
endpackage

// File: hdl/dword_keep_mask.sv
`timescale 1ns/1ps
module dword_keep_mask #(
  parameter int DWORDS = 16,
  parameter int PW = $clog2(DWORDS)
) (
  input wire logic [PW-1:0] end_ptr_i,
  input wire logic full_i,
  output logic [4*DWORDS-1:0] keep_o
);
  import cq_frame_pkg::*;

  // every dword up to the last one keeps its four bytes
  genvar i;
  generate
    for (i = 0; i < DWORDS; i++) begin : g_dw
      localparam logic [PW-1:0] IDX = PW'(i);
      assign keep_o[4*i +: 4] = {4{full_i || (IDX <= end_ptr_i)}};
    end
  endgenerate
endmodule

// File: hdl/pcie_completer_stream_framing.sv
// Function
// - with straddle on, a new request may start when the previous ended by dword 7.
// - straddle works only with dword-aligned placement, never with 128-bit aligned.
// - under straddle, byte keep is all ones and last stays low.
// - start flag 0 marks a start; lane 32 start only with end flag 0.
// - start flag 1 marks two starts, at lanes 0 and 32, after an end.
// - end flag 0 marks an end; first offset gives its last dword.
// - end flag 1 marks a second end, needs end flag 0, offset 11 to 15.
// - with dword-aligned placement, payload dwords follow the descriptor with no gap.
// - completion stream has a straddle bit, shown in status only; completions are never packed two per beat.
// - completion valid must stay high through a packet; a drop nullifies it.
`timescale 1ns/1ps
module pcie_completer_stream_framing (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [cq_frame_pkg::APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [cq_frame_pkg::HALF_BITS-1:0] req_in_data_i,
  input wire logic req_in_valid_i,
  input wire logic req_in_sop_i,
  input wire logic req_in_eop_i,
  input wire logic [2:0] req_in_end_ptr_i,
  output logic req_in_ready_o,
  output logic [cq_frame_pkg::BEAT_BITS-1:0] request_out_data_o,
  output logic request_out_valid_o,
  input wire logic request_out_ready_i,
  output logic [cq_frame_pkg::BEAT_BYTES-1:0] request_out_byte_keep_o,
  output logic request_out_last_o,
  output logic [1:0] tlp_start_flags_o,
  output logic [1:0] tlp_end_flags_o,
  output logic [3:0] first_end_dword_offset_o,
  output logic [3:0] second_end_dword_offset_o,
  input wire logic [cq_frame_pkg::BEAT_BITS-1:0] completion_in_data_i,
  input wire logic completion_in_valid_i,
  input wire logic completion_in_last_i,
  output logic completion_in_ready_o,
  output logic [cq_frame_pkg::BEAT_BITS-1:0] cpl_out_data_o,
  output logic cpl_out_valid_o,
  output logic cpl_out_last_o,
  output logic cpl_out_sop_o,
  output logic cpl_out_nullify_o,
  output logic [5:0] cpl_payload_lane_o,
  output logic [10:0] cpl_dword_count_o,
  output logic [2:0] cpl_status_o,
  input wire logic cpl_out_ready_i
);
  import cq_frame_pkg::*;

  typedef struct packed {
    slot_t slot;
    logic [BEAT_BITS-1:0] beat;
    logic [1:0] sop;
    logic [1:0] eop;
    logic [3:0] ptr0;
    logic [3:0] ptr1;
    logic ovalid;
    logic olast;
    logic kfull;
    logic [CTRL_BITS-1:0] ctrl;
    logic [31:0] req_count;
    logic [31:0] cpl_count;
    logic [ERR_BITS-1:0] err;
    logic [31:0] prdata;
    logic pslverr;
    logic in_pkt;
    logic [BEAT_BITS-1:0] cdata;
    logic cvalid;
    logic clast;
    logic csop;
    logic cnull;
    logic [5:0] lane;
    logic [10:0] dwc;
    logic [2:0] cstat;
  } frame_state_t;

  frame_state_t s;
  frame_state_t next_s;
  logic straddle;
  logic cc_straddle;
  logic out_free;
  logic req_take;
  logic cpl_free;
  logic cpl_take;
  logic emit;
  logic [ERR_BITS-1:0] err_set;
  logic [ERR_BITS-1:0] err_clr;
  logic [5:0] dec_lane;
  logic [10:0] dec_dwc;
  logic [2:0] dec_status;
  logic dec_status_bad;
  logic dec_count_bad;

  // straddle is forced off whenever 128-bit aligned placement is chosen
  assign straddle = s.ctrl[CTRL_STRADDLE] && !s.ctrl[CTRL_ALIGNED];
  assign cc_straddle = s.ctrl[CTRL_CC_STRADDLE] && !s.ctrl[CTRL_ALIGNED];
  assign out_free = !s.ovalid || request_out_ready_i;
  assign req_take = req_in_valid_i && out_free;
  assign cpl_free = !s.cvalid || cpl_out_ready_i;
  assign cpl_take = completion_in_valid_i && cpl_free;

  // descriptor starts at lane 0: two completions per beat are not packed here
  cpl_desc_decode u_desc (
    .desc_i(completion_in_data_i[DESC_BITS-1:0]),
    .aligned_mode_i(s.ctrl[CTRL_ALIGNED]),
    .start_upper_i(1'b0),
    .payload_lane_o(dec_lane),
    .dword_count_o(dec_dwc),
    .status_o(dec_status),
    .status_bad_o(dec_status_bad),
    .count_bad_o(dec_count_bad)
  );

  dword_keep_mask #(
    .DWORDS(BEAT_DWORDS)
  ) u_keep (
    .end_ptr_i(s.ptr0),
    .full_i(s.kfull),
    .keep_o(request_out_byte_keep_o)
  );

  // next-state logic: request framer, completion pass, register file
  always_comb begin
    next_s = s;
    emit = 1'b0;
    err_set = '0;
    err_clr = '0;
    next_s.cnull = 1'b0;
    if (s.ovalid && request_out_ready_i) begin
      next_s.ovalid = 1'b0;
    end
    // halves are packed back to back, so payload stays right behind the header
    case (s.slot)
      SLOT_LOW: begin
        if (req_take) begin
          next_s.beat = {{HALF_BITS{1'b0}}, req_in_data_i};
          next_s.sop = {1'b0, req_in_sop_i};
          next_s.eop = {1'b0, req_in_eop_i};
          next_s.ptr0 = req_in_eop_i ? {1'b0, req_in_end_ptr_i} : 4'h0;
          next_s.ptr1 = 4'h0;
          if (!req_in_eop_i) begin
            next_s.slot = SLOT_HIGH;
          end else if (straddle) begin
            next_s.slot = SLOT_HIGH_NEW;
          end else begin
            emit = 1'b1;
            next_s.ovalid = 1'b1;
            next_s.olast = 1'b1;
            next_s.kfull = 1'b0;
          end
        end
      end
      SLOT_HIGH: begin
        if (req_take) begin
          emit = 1'b1;
          next_s.beat[BEAT_BITS-1:HALF_BITS] = req_in_data_i;
          next_s.eop = {1'b0, req_in_eop_i};
          next_s.ptr0 = req_in_eop_i ? UPPER_DWORD_BASE + {1'b0, req_in_end_ptr_i} : 4'h0;
          next_s.ovalid = 1'b1;
          next_s.olast = req_in_eop_i && !straddle;
          next_s.kfull = straddle || !req_in_eop_i;
          next_s.slot = SLOT_LOW;
        end
      end
      SLOT_HIGH_NEW: begin
        // a start in the upper half always rides with the end in the lower half
        if (req_take) begin
          emit = 1'b1;
          next_s.beat[BEAT_BITS-1:HALF_BITS] = req_in_data_i;
          next_s.sop = {s.sop[0], 1'b1};
          next_s.eop = {req_in_eop_i, 1'b1};
          next_s.ptr1 = req_in_eop_i ? UPPER_DWORD_BASE + {1'b0, req_in_end_ptr_i} : 4'h0;
          next_s.ovalid = 1'b1;
          next_s.olast = 1'b0;
          next_s.kfull = 1'b1;
          next_s.slot = SLOT_LOW;
        end else if (!req_in_valid_i && out_free) begin
          // nothing to share the beat with: send it rather than stall the packet
          emit = 1'b1;
          next_s.ovalid = 1'b1;
          next_s.olast = 1'b0;
          next_s.kfull = 1'b1;
          next_s.slot = SLOT_LOW;
        end
      end
      default: begin
        next_s.slot = SLOT_LOW;
      end
    endcase
    next_s.req_count = s.req_count + 32'(req_take && req_in_sop_i);

    // completion stream: one register stage, descriptor checked on the first beat
    if (s.cvalid && cpl_out_ready_i) begin
      next_s.cvalid = 1'b0;
    end
    if (cpl_take) begin
      next_s.cdata = completion_in_data_i;
      next_s.cvalid = 1'b1;
      next_s.clast = completion_in_last_i;
      next_s.csop = !s.in_pkt;
      next_s.in_pkt = !completion_in_last_i;
      if (!s.in_pkt) begin
        next_s.lane = dec_lane;
        next_s.dwc = dec_dwc;
        next_s.cstat = dec_status;
        next_s.cpl_count = s.cpl_count + 32'h0000_0001;
        err_set[ERR_BAD_STATUS] = dec_status_bad;
        err_set[ERR_BAD_COUNT] = dec_count_bad;
      end
    end else if (s.in_pkt && !completion_in_valid_i) begin
      // valid fell inside a packet: kill what was sent and resync on next start
      next_s.cnull = 1'b1;
      next_s.in_pkt = 1'b0;
      err_set[ERR_VALID_DROP] = 1'b1;
    end

    // apb: decode and read data captured in the setup cycle, writes in access
    if (psel_i && !penable_i) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (paddr_i == ADDR_CTRL) begin
        next_s.prdata = 32'(s.ctrl);
      end else if (paddr_i == ADDR_STATUS) begin
        next_s.prdata = 32'({s.slot, s.in_pkt, cc_straddle,
                             s.ctrl[CTRL_STRADDLE] && s.ctrl[CTRL_ALIGNED], straddle});
      end else if (paddr_i == ADDR_REQ_COUNT) begin
        next_s.prdata = s.req_count;
      end else if (paddr_i == ADDR_CPL_COUNT) begin
        next_s.prdata = s.cpl_count;
      end else if (paddr_i == ADDR_CPL_ERR) begin
        next_s.prdata = 32'(s.err);
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (psel_i && penable_i && pwrite_i && pstrb_i[0]) begin
      if (paddr_i == ADDR_CTRL) begin
        next_s.ctrl = pwdata_i[CTRL_BITS-1:0];
      end else if (paddr_i == ADDR_CPL_ERR) begin
        err_clr = pwdata_i[ERR_BITS-1:0];
      end
    end
    // a new error in the clearing cycle survives the clear
    next_s.err = (s.err & ~err_clr) | err_set;
  end

  // single state register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state, except pready_o, tied high, and the two input readies, which also follow the downstream ready inputs
  assign prdata_o = s.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = s.pslverr;
  assign req_in_ready_o = out_free;
  assign request_out_data_o = s.beat;
  assign request_out_valid_o = s.ovalid;
  assign request_out_last_o = s.olast;
  assign tlp_start_flags_o = s.sop;
  assign tlp_end_flags_o = s.eop;
  assign first_end_dword_offset_o = s.ptr0;
  assign second_end_dword_offset_o = s.ptr1;
  assign completion_in_ready_o = cpl_free;
  assign cpl_out_data_o = s.cdata;
  assign cpl_out_valid_o = s.cvalid;
  assign cpl_out_last_o = s.clast;
  assign cpl_out_sop_o = s.csop;
  assign cpl_out_nullify_o = s.cnull;
  assign cpl_payload_lane_o = s.lane;
  assign cpl_dword_count_o = s.dwc;
  assign cpl_status_o = s.cstat;

  // checks on the framer and the completion path
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence low_end_straddle;
    s.slot == SLOT_LOW && req_take && req_in_eop_i && straddle;
  endsequence

  sequence upper_start;
    req_take && req_in_sop_i;
  endsequence

  sequence low_end_plain;
    s.slot == SLOT_LOW && req_take && req_in_eop_i && !straddle;
  endsequence

  a_upper_start: assert property (low_end_straddle ##1 upper_start |=>
    request_out_valid_o && tlp_start_flags_o[0] && tlp_end_flags_o[0]
    && request_out_data_o[BEAT_BITS-1:HALF_BITS] == $past(req_in_data_i)
    && first_end_dword_offset_o == {1'b0, $past(req_in_end_ptr_i, 2)})
    else $error("upper-half start not framed after a lower-half end");

  a_end_offset: assert property (low_end_plain |=>
    request_out_valid_o && tlp_end_flags_o[0] && request_out_last_o
    && first_end_dword_offset_o == {1'b0, $past(req_in_end_ptr_i)})
    else $error("end offset or last wrong for a lower-half end");

  a_keep_straddle: assert property ($past(emit && straddle) |->
    (&request_out_byte_keep_o) && !request_out_last_o)
    else $error("keep or last not held in straddle mode");

  a_flag_pairs: assert property (request_out_valid_o
    && (tlp_start_flags_o[1] || tlp_end_flags_o[1]) |-> tlp_start_flags_o[0] && tlp_end_flags_o[0])
    else $error("bit 1 flag without bit 0 flags");

  a_second_end: assert property (request_out_valid_o && tlp_end_flags_o[1] |->
    second_end_dword_offset_o >= EOP1_MIN_PTR)
    else $error("second end offset below 11");

  a_aligned_solo: assert property (s.ctrl[CTRL_ALIGNED] |-> !straddle && !cc_straddle)
    else $error("straddle active with 128-bit aligned placement");

  a_cpl_nullify: assert property (s.in_pkt && !completion_in_valid_i |=>
    cpl_out_nullify_o && s.err[ERR_VALID_DROP] && !s.in_pkt)
    else $error("completion valid drop not nullified");

  a_bad_status: assert property (cpl_take && !s.in_pkt && dec_status_bad |=>
    s.err[ERR_BAD_STATUS] && cpl_out_sop_o)
    else $error("illegal completion status not flagged");

  a_out_hold: assert property (request_out_valid_o && !request_out_ready_i |=>
    request_out_valid_o && $stable(request_out_data_o) && $stable(tlp_end_flags_o))
    else $error("request beat changed while stalled");
endmodule

// File: verif/cq_user_model.sv
`timescale 1ns/1ps
module cq_user_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic completion_in_ready_i,
  output logic [511:0] completion_in_data_o,
  output logic completion_in_valid_o,
  output logic completion_in_last_o,
  output logic request_out_ready_o
);
  integer seed = 87334;
  initial begin
    completion_in_data_o = '0;
    completion_in_valid_o = 1'b0;
    completion_in_last_o = 1'b0;
  end
  // random stalls keep request beats held under back-pressure now and then
  always @(posedge mclk_i) begin
    request_out_ready_o <= rst_i | (($random(seed) & 3) != 0);
  end
  // one completion packet; drop abandons it after the first beat
  task automatic send_cpl(input logic [95:0] desc, input logic [415:0] pay, input int beats, input bit drop);
    logic ok;
    for (int b = 0; b < beats; b++) begin
      completion_in_valid_o <= 1'b1;
      completion_in_data_o <= (b == 0) ? {pay, desc} : {16{$random(seed)}};
      completion_in_last_o <= (b == beats - 1);
      do begin
        @(negedge mclk_i) ok = completion_in_ready_i;
        @(posedge mclk_i);
      end while (!ok);
      if (drop) begin
        break;
      end
    end
    // released bus shows the inverse so a stale beat never passes for data
    completion_in_valid_o <= 1'b0;
    completion_in_last_o <= 1'b0;
    completion_in_data_o <= ~completion_in_data_o;
    @(posedge mclk_i);
  endtask
endmodule

// File: verif/test_pcie_completer_stream_framing.sv
`timescale 1ns/1ps
module test_pcie_completer_stream_framing;
  import cq_frame_pkg::*;
  logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0] pstrb_i, first_end_dword_offset_o, second_end_dword_offset_o;
  logic [255:0] req_in_data_i, a, b;
  logic req_in_valid_i, req_in_sop_i, req_in_eop_i, req_in_ready_o;
  logic [2:0] req_in_end_ptr_i, cpl_status_o;
  logic [511:0] request_out_data_o, completion_in_data_i, cpl_out_data_o;
  logic request_out_valid_o, request_out_ready_i, request_out_last_o;
  logic [63:0] request_out_byte_keep_o;
  logic [1:0] tlp_start_flags_o, tlp_end_flags_o;
  logic completion_in_valid_i, completion_in_last_i, completion_in_ready_o;
  logic cpl_out_valid_o, cpl_out_last_o, cpl_out_sop_o, cpl_out_nullify_o, cpl_out_ready_i;
  logic [5:0] cpl_payload_lane_o;
  logic [10:0] cpl_dword_count_o;
  logic [6:0] la;
  logic [588:0] rq[$];
  logic [531:0] cq[$];
  logic [32:0] aq[$];
  integer seed = 87334;
  int errors = 0, n_checks = 0, n_null = 0;

  pcie_completer_stream_framing i_pcie_completer_stream_framing (.*);
  cq_user_model i_cq_user_model (.mclk_i(mclk_i), .rst_i(rst_i), .completion_in_ready_i(completion_in_ready_o),
    .completion_in_data_o(completion_in_data_i), .completion_in_valid_o(completion_in_valid_i),
    .completion_in_last_o(completion_in_last_i), .request_out_ready_o(request_out_ready_i));

  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  // completion sink stalls at random
  always @(posedge mclk_i) cpl_out_ready_i <= ($random(seed) & 1) | rst_i;

  task automatic check(input logic [599:0] got, input logic [599:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: output differs from expected", $time);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // monitor: sampled at mid-cycle, where a handshake about to complete is settled
  always @(negedge mclk_i) if (!rst_i) begin
    if (request_out_valid_o && request_out_ready_i) begin
      logic [588:0] e;
      e = rq.pop_front();
      check({request_out_data_o, request_out_byte_keep_o, request_out_last_o, tlp_start_flags_o, tlp_end_flags_o,
        first_end_dword_offset_o, e[9] ? second_end_dword_offset_o : e[3:0]}, e);
    end
    if (cpl_out_valid_o && cpl_out_ready_i && cpl_out_sop_o)
      check({cpl_out_data_o, cpl_payload_lane_o, cpl_dword_count_o, cpl_status_o}, cq.pop_front());
    if (psel_i && penable_i && pready_o && !pwrite_i) check({pslverr_o, prdata_o}, aq.pop_front());
    if (cpl_out_nullify_o) n_null++;
  end

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    logic ok;
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= ad; pwdata_i <= d;
    @(posedge mclk_i) penable_i <= 1;
    do begin
      @(negedge mclk_i) ok = pready_o;
      @(posedge mclk_i);
    end while (!ok);
    psel_i <= 0; penable_i <= 0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    aq.push_back(e);
    apb(0, ad, '0);
  endtask

  // one request half; valid stays up so halves can follow back to back
  task automatic half(input logic [255:0] d, input logic s, input logic e, input logic [2:0] p);
    logic ok;
    req_in_valid_i <= 1; req_in_data_i <= d; req_in_sop_i <= s; req_in_eop_i <= e; req_in_end_ptr_i <= p;
    do begin
      @(negedge mclk_i) ok = req_in_ready_o;
      @(posedge mclk_i);
    end while (!ok);
  endtask
  // packs one expected beat in the monitor's field order
  function automatic logic [588:0] ex(input logic [255:0] hi, input logic [255:0] lo, input logic [63:0] k,
    input logic l, input logic [1:0] so, input logic [1:0] eo, input logic [3:0] p0, input logic [3:0] p1);
    return {hi, lo, k, l, so, eo, p0, p1};
  endfunction
  task automatic idle;
    req_in_valid_i <= 0; req_in_data_i <= ~req_in_data_i;
    for (int i = 0; i < 60 && rq.size() != 0; i++) @(posedge mclk_i);
  endtask

  task automatic cpl(input logic [10:0] dw, input logic [2:0] st, input int n, input bit drop, input logic [5:0] ln);
    logic [95:0] d;
    logic [415:0] p;
    d = '0;
    d[6:0] = la;
    d[9:8] = 2'h0;
    d[28:16] = {dw, 2'b00};
    d[29] = 1'b0;
    d[46] = 1'b0;
    d[42:32] = dw;
    d[45:43] = st;
    d[71:48] = 24'($random(seed));
    d[91:89] = 3'h5;
    p = {13{$random(seed)}};
    cq.push_back({p, d, ln, dw, st});
    i_cq_user_model.send_cpl(d, p, n, drop);
  endtask

  initial begin
    rst_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = '0; pwdata_i = '0; pstrb_i = 4'hf;
    req_in_data_i = '0; req_in_valid_i = 0; req_in_sop_i = 0; req_in_eop_i = 0; req_in_end_ptr_i = '0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    rd(ADDR_CTRL, 33'h0);
    rd(ADDR_STATUS, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    a = {8{$random(seed)}};
    b = {8{$random(seed)}};
    // no straddle: lone low-half packet, then one spanning both halves
    rq.push_back(ex(256'h0, a, 64'h0000_0000_0000_0fff, 1, 2'b01, 2'b01, 4'h2, 4'h0));
    half(a, 1, 1, 2);
    idle();
    rq.push_back(ex(b, a, 64'h0000_ffff_ffff_ffff, 1, 2'b01, 2'b01, 4'hb, 4'h0));
    half(a, 1, 0, 0);
    half(b, 0, 1, 3);
    idle();
    // straddle asked with aligned placement is refused, framing stays plain
    apb(1, ADDR_CTRL, 32'h0000_0003);
    rd(ADDR_STATUS, 33'h2);
    rq.push_back(ex(256'h0, a, 64'h0000_0000_0000_0fff, 1, 2'b01, 2'b01, 4'h2, 4'h0));
    half(a, 1, 1, 2);
    idle();
    apb(1, ADDR_CTRL, 32'h0000_0001);
    rd(ADDR_STATUS, 33'h1);
    rq.push_back(ex(b, a, {64{1'b1}}, 0, 2'b11, 2'b11, 4'h7, 4'hf));
    half(a, 1, 1, 7);
    half(b, 1, 1, 7);
    idle();
    rq.push_back(ex(b, a, {64{1'b1}}, 0, 2'b01, 2'b01, 4'hb, 4'h0));
    half(a, 1, 0, 0);
    half(b, 0, 1, 3);
    idle();
    rq.push_back(ex(256'h0, a, {64{1'b1}}, 0, 2'b01, 2'b01, 4'h6, 4'h0));
    half(a, 1, 1, 6);
    idle();
    rd(ADDR_REQ_COUNT, 33'h7);
    // every legal status code, dword-aligned lanes
    for (int i = 0; i < 3; i++) begin
      la = 7'($random(seed));
      cpl(i == 0 ? 11'h5 : 11'h0, i == 0 ? CPL_STATUS_SC : (i == 1 ? CPL_STATUS_UR : CPL_STATUS_CA),
        i == 0 ? 2 : 1, 0, 6'(12 + la[1:0]));
    end
    rd(ADDR_CPL_ERR, 33'h0);
    apb(1, ADDR_CTRL, 32'h0000_0002);
    la = 7'($random(seed));
    cpl(11'h3, CPL_STATUS_SC, 3, 0, 6'(16 + la[3:0]));
    cpl(11'h0, 3'h2, 1, 0, 6'(16 + la[3:0]));
    rd(ADDR_CPL_ERR, 33'h2);
    apb(1, ADDR_CPL_ERR, 32'h0000_0007);
    rd(ADDR_CPL_ERR, 33'h0);
    cpl(11'h5, CPL_STATUS_UR, 1, 0, 6'(16 + la[3:0]));
    rd(ADDR_CPL_ERR, 33'h4);
    apb(1, ADDR_CPL_ERR, 32'h0000_0007);
    cpl(11'h2, CPL_STATUS_SC, 2, 1, 6'(16 + la[3:0]));
    rd(ADDR_CPL_ERR, 33'h1);
    check(n_null, 1);
    close_out();
  end

  initial begin
    #300000;
    errors++;
    close_out();
  end
endmodule
